// ### byte_fifo.sv
// First-in first-out byte store with synchronous clear.
// Assumes the caller never pushes when full nor pops when empty; such requests are ignored.
`timescale 1ns/100ps
`include "host_port_defs.svh"

module byte_fifo
    import host_port_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
)(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic             clear_in,
    input  wire logic             push_in,
    input  wire logic [WIDTH-1:0] push_data_in,
    input  wire logic             pop_in,
    output logic      [WIDTH-1:0] head_out,
    output logic      [AW:0]      count_out,
    output logic                  full_out,
    output logic                  empty_out
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    wire              do_push = push_in & ~full_out;
    wire              do_pop  = pop_in & ~empty_out;

    // Status is a plain decode of the count; head is a plain read at the read pointer
    assign head_out  = mem[rd_ptr_r];
    assign count_out = count_r;
    assign full_out  = (count_r == (AW+1)'(DEPTH));
    assign empty_out = (count_r == '0);

    // Storage has no reset; head_out shows a stale or unwritten word while the count is zero
    always_ff @(posedge clk_in)
    begin
        if (ce_in && do_push && !clear_in)
            mem[wr_ptr_r] <= push_data_in;
    end

    // Pointer and count update; clear drops everything at once
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else if (ce_in)
        begin
            if (clear_in)
            begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
                count_r  <= '0;
            end
            else
            begin
                wr_ptr_r <= wr_ptr_r + AW'(do_push);
                rd_ptr_r <= rd_ptr_r + AW'(do_pop);
                count_r  <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
            end
        end
    end

endmodule // byte_fifo

// ### host_port_defs.svh
// Offsets, field positions, reset values and counts for the host register port.
// Assumes inclusion by the package and by the design files that decode host accesses.
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// Register offsets within the eight-location block
`define OFS_DATA        3'h0
`define OFS_INT_ENABLE  3'h1
`define OFS_INT_ID      3'h2
`define OFS_LINE_CTRL   3'h3
`define OFS_SPARE       3'h4
`define OFS_LINE_STAT   3'h5
`define OFS_LINK_STAT   3'h6
`define OFS_CARD_ID     3'h7

// Field positions
`define LCR_DIVISOR_LATCH_ACCESS_BIT_BIT    7
`define RST_RXFIFO_BIT  1
`define RST_TXFIFO_BIT  2
`define RST_CPU_BIT     4
`define IER_RXDATA_BIT  0
`define IER_TXEMPTY_BIT 1
`define IER_LINE_BIT    2
`define IER_REMOTE_BIT  3
`define LSR_DREADY_BIT  0
`define LSR_OVERRUN_BIT 1
`define LSR_FRAMING_BIT 3
`define LSR_TXREADY_BIT 5
`define MSR_REMOTE_BIT  4

// Reset values
`define LCR_RESET       8'h00
`define IER_RESET       4'h0
`define BAUD_RESET      8'h00
`define BAUD_DEFAULT    8'h01

// Sizes and counts
`define FIFO_DEPTH      512
`define ADDR_LINES      10
`define LOW_ADDR_LINES  3

`endif

// ### host_port_pkg.sv
// Types shared by the host register port and its buffer.
// Assumes the defines header for widths.
`include "host_port_defs.svh"

package host_port_pkg;

    // Interrupt identification codes, bits 2..0 of the identification register
    typedef enum logic [2:0] {
        INT_NONE    = 3'b001,
        INT_LINE    = 3'b110,
        INT_RXDATA  = 3'b100,
        INT_TXEMPTY = 3'b010,
        INT_REMOTE  = 3'b000
    } int_id_t;

    // Host-side pin group, carried through the input synchroniser as one word
    typedef struct packed {
        logic                       rd_n;
        logic                       wr_n;
        logic [`ADDR_LINES-1:0]     addr;
        logic [7:0]                 wdata;
        logic [`ADDR_LINES-`LOW_ADDR_LINES-1:0] base_sel;
        logic                       mode;
        logic                       remote_irq;
    } host_pins_t;

endpackage

// ### host_reg_port.sv
// Host I/O register port of a serial adapter: eight byte registers behind a jumper-set base.
// Assumes host strobes, address, data and jumpers arrive asynchronously; card-side ports are on clk_in.
`timescale 1ns/100ps
`include "host_port_defs.svh"
module host_reg_port
    import host_port_pkg::*;
#(
    parameter int         IRQ_LINES = 8,
    parameter int         DEPTH     = `FIFO_DEPTH,
    parameter logic [7:0] CARD_ID   = 8'hA5   // Arbitrary identifier value
)(
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 ce_in,
    input  wire logic                 io_rd_n_in,
    input  wire logic                 io_wr_n_in,
    input  wire logic [9:0]           io_addr_in,
    input  wire logic [7:0]           io_data_in,
    output logic      [7:0]           io_data_out,
    output logic                      io_data_oe_n_out,
    input  wire logic [6:0]           base_sel_in,
    input  wire logic [IRQ_LINES-1:0] irq_sel_in,
    input  wire logic                 mode_sel_in,
    input  wire logic                 remote_irq_in,
    output logic      [IRQ_LINES-1:0] irq_out,
    output logic                      tx_valid_out,
    output logic      [7:0]           tx_data_out,
    input  wire logic                 tx_ready_in,
    input  wire logic                 rx_valid_in,
    input  wire logic [7:0]           rx_data_in,
    output logic                      rx_ready_out,
    input  wire logic                 rx_frame_err_in,
    input  wire logic                 response_done_in,
    output logic      [7:0]           baud_code_out,
    output logic      [6:0]           word_format_out,
    output logic                      cpu_reset_out
);

    localparam int SW = $bits(host_pins_t) + IRQ_LINES;
    localparam int AW = $clog2(DEPTH);
    localparam host_pins_t PIN_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
    localparam logic [SW-1:0] SYNC_RESET = {PIN_IDLE, {IRQ_LINES{1'b0}}};

    // Baud codes that the link processor understands
    function automatic logic baud_valid(input logic [7:0] code);
        unique case (code)
            8'h17, 8'h00, 8'h80, 8'hC0, 8'h60, 8'h30, 8'h18, 8'h0C, 8'h06,
            8'h03, 8'h02, 8'hF0, 8'h01, 8'hF4, 8'hF3, 8'hF5, 8'hF6: baud_valid = 1'b1;
            default: baud_valid = 1'b0;
        endcase
    endfunction

    // Three-stage pin synchroniser; a bit moves only when stages two and three agree
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [SW-1:0] s3_r;
    logic [SW-1:0] flt_r;
    logic [SW-1:0] sync_raw;
    assign sync_raw = {io_rd_n_in, io_wr_n_in, io_addr_in, io_data_in, base_sel_in,
                       mode_sel_in, remote_irq_in, irq_sel_in};

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s1_r <= SYNC_RESET;
            s2_r <= SYNC_RESET;
            s3_r <= SYNC_RESET;
        end
        else if (ce_in)
        begin
            s1_r <= sync_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++)
        begin : g_filter
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    flt_r[gi] <= SYNC_RESET[gi];
                else if (ce_in && (s2_r[gi] == s3_r[gi]))
                    flt_r[gi] <= s3_r[gi];
            end
        end
    endgenerate

    host_pins_t               pins;
    logic [IRQ_LINES-1:0]     irq_sel;
    assign pins    = flt_r[SW-1:IRQ_LINES];
    assign irq_sel = flt_r[IRQ_LINES-1:0];

    // State registers
    logic       rd_n_d_r;
    logic       wr_n_d_r;
    logic [9:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic [7:0] lcr_r;
    logic [3:0] ier_r;
    logic [7:0] brs_r;
    logic       overrun_r;
    logic       framing_r;
    logic       resp_ready_r;

    // Access decode: strobe edges of the filtered pins
    wire rd_start = ce_in & rd_n_d_r & ~pins.rd_n;
    wire wr_end   = ce_in & ~wr_n_d_r & pins.wr_n;
    wire rd_hit   = (pins.addr[9:3] == pins.base_sel);
    wire wr_hit   = (wr_addr_r[9:3] == pins.base_sel);
    wire [2:0] rd_ofs = pins.addr[2:0];
    wire [2:0] wr_ofs = wr_addr_r[2:0];
    wire divisor_latch_access_bit     = lcr_r[`LCR_DIVISOR_LATCH_ACCESS_BIT_BIT];
    wire rd_go    = rd_start & rd_hit;
    wire wr_go    = wr_end & wr_hit;
    wire wr_data0 = wr_go & (wr_ofs == `OFS_DATA) & ~divisor_latch_access_bit;
    wire wr_baud  = wr_go & (wr_ofs == `OFS_DATA) & divisor_latch_access_bit;
    wire wr_ier   = wr_go & (wr_ofs == `OFS_INT_ENABLE) & ~divisor_latch_access_bit;
    wire wr_rst   = wr_go & (wr_ofs == `OFS_INT_ID);
    wire wr_lcr   = wr_go & (wr_ofs == `OFS_LINE_CTRL);
    wire rd_data0 = rd_go & (rd_ofs == `OFS_DATA) & ~divisor_latch_access_bit;
    wire rd_lsr   = rd_go & (rd_ofs == `OFS_LINE_STAT);
    wire cpu_rst  = wr_rst & wr_data_r[`RST_CPU_BIT] & divisor_latch_access_bit;
    wire rx_clr   = (wr_rst & wr_data_r[`RST_RXFIFO_BIT]) | cpu_rst;
    wire tx_clr   = (wr_rst & wr_data_r[`RST_TXFIFO_BIT]) | cpu_rst;

    // Buffers between host and link processor
    logic [7:0]  rx_head;
    logic [7:0]  tx_head;
    logic [AW:0] rx_count;
    logic        rx_full;
    logic        rx_empty;
    logic        tx_full;
    logic        tx_empty;
    wire         rx_push = rx_valid_in & rx_ready_out;
    wire         rx_pop  = rd_data0 & ~rx_empty;
    wire         tx_pop  = ce_in & ~tx_empty & ~tx_clr & (~tx_valid_out | tx_ready_in);
    wire         tx_push = wr_data0 & ~tx_full;
    wire [AW:0]  rx_count_nxt = rx_clr ? '0 : rx_count + (AW+1)'(rx_push) - (AW+1)'(rx_pop);

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .ce_in        (ce_in),
        .clear_in     (rx_clr),
        .push_in      (rx_push),
        .push_data_in (rx_data_in),
        .pop_in       (rx_pop),
        .head_out     (rx_head),
        .count_out    (rx_count),
        .full_out     (rx_full),
        .empty_out    (rx_empty)
    );

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .ce_in        (ce_in),
        .clear_in     (tx_clr),
        .push_in      (tx_push),
        .push_data_in (wr_data_r),
        .pop_in       (tx_pop),
        .head_out     (tx_head),
        .count_out    (),
        .full_out     (tx_full),
        .empty_out    (tx_empty)
    );

    // Status words; mode 1 hides data until a whole response is in
    wire data_ready = ~rx_empty & (~pins.mode | resp_ready_r);
    wire tx_room    = ~tx_full;
    wire line_int   = ier_r[`IER_LINE_BIT] & (overrun_r | framing_r);
    wire rxd_int    = ier_r[`IER_RXDATA_BIT] & data_ready;
    wire txe_int    = ier_r[`IER_TXEMPTY_BIT] & tx_room;
    wire rem_int    = ier_r[`IER_REMOTE_BIT] & pins.remote_irq;
    wire int_pend   = line_int | rxd_int | txe_int | rem_int;
    int_id_t int_id;
    assign int_id = line_int ? INT_LINE : rxd_int ? INT_RXDATA :
                    txe_int ? INT_TXEMPTY : rem_int ? INT_REMOTE : INT_NONE;

    logic [7:0] lsr_val;
    logic [7:0] msr_val;
    logic [7:0] rd_mux;
    always_comb
    begin
        lsr_val = 8'h00;
        lsr_val[`LSR_DREADY_BIT]  = data_ready;
        lsr_val[`LSR_OVERRUN_BIT] = overrun_r;
        lsr_val[`LSR_FRAMING_BIT] = framing_r;
        lsr_val[`LSR_TXREADY_BIT] = tx_room;
        msr_val = 8'h00;
        msr_val[`MSR_REMOTE_BIT]  = pins.remote_irq;
    end

    // Read data select by offset
    always_comb
    begin
        unique case (rd_ofs)
            `OFS_DATA:       rd_mux = divisor_latch_access_bit ? brs_r : (data_ready ? rx_head : 8'h00);
            `OFS_INT_ENABLE: rd_mux = divisor_latch_access_bit ? 8'h00 : {4'h0, ier_r};
            `OFS_INT_ID:     rd_mux = {5'h00, int_id};
            `OFS_LINE_CTRL:  rd_mux = lcr_r;
            `OFS_SPARE:      rd_mux = 8'h00;
            `OFS_LINE_STAT:  rd_mux = lsr_val;
            `OFS_LINK_STAT:  rd_mux = msr_val;
            `OFS_CARD_ID:    rd_mux = CARD_ID;
        endcase
    end

    // Host bus side: strobe history, write capture and read data drive
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_n_d_r         <= 1'b1;
            wr_n_d_r         <= 1'b1;
            wr_addr_r        <= '0;
            wr_data_r        <= 8'h00;
            io_data_out      <= 8'h00;
            io_data_oe_n_out <= 1'b1;
        end
        else if (ce_in)
        begin
            rd_n_d_r         <= pins.rd_n;
            wr_n_d_r         <= pins.wr_n;
            // Held one cycle behind so the data survives the strobe's end
            if (!pins.wr_n)
            begin
                wr_addr_r <= pins.addr;
                wr_data_r <= pins.wdata;
            end
            if (rd_go)
                io_data_out  <= rd_mux;
            io_data_oe_n_out <= ~(rd_hit & ~pins.rd_n);
        end
    end

    // Control registers; a card reset wipes them like a power cycle
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lcr_r <= `LCR_RESET;
            ier_r <= `IER_RESET;
            brs_r <= `BAUD_RESET;
        end
        else if (ce_in)
        begin
            if (cpu_rst)
            begin
                lcr_r <= `LCR_RESET;
                ier_r <= `IER_RESET;
                brs_r <= `BAUD_RESET;
            end
            else
            begin
                if (wr_lcr)
                    lcr_r <= wr_data_r;
                if (wr_ier)
                    ier_r <= wr_data_r[3:0];
                if (wr_baud)
                    brs_r <= wr_data_r;
            end
        end
    end

    // Sticky error and response flags; a new event wins over the clear
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            overrun_r    <= 1'b0;
            framing_r    <= 1'b0;
            resp_ready_r <= 1'b0;
        end
        else if (ce_in)
        begin
            overrun_r    <= (rx_valid_in & rx_full) | (overrun_r & ~rd_lsr);
            framing_r    <= rx_frame_err_in | (framing_r & ~rd_lsr);
            resp_ready_r <= response_done_in | (resp_ready_r & (rx_count_nxt != '0));
        end
    end

    // Card-side outputs, all registered
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_valid_out    <= 1'b0;
            tx_data_out     <= 8'h00;
            rx_ready_out    <= 1'b0;
            baud_code_out   <= `BAUD_DEFAULT;
            word_format_out <= 7'h00;
            cpu_reset_out   <= 1'b0;
            irq_out         <= '0;
        end
        else if (ce_in)
        begin
            if (tx_pop)
            begin
                tx_valid_out <= 1'b1;
                tx_data_out  <= tx_head;
            end
            else if (tx_ready_in || tx_clr)
                tx_valid_out <= 1'b0;
            // Ready from the next count, so the buffer can never be overfilled
            rx_ready_out    <= (rx_count_nxt < (AW+1)'(DEPTH));
            baud_code_out   <= baud_valid(brs_r) ? brs_r : `BAUD_DEFAULT;
            word_format_out <= lcr_r[6:0];
            cpu_reset_out   <= cpu_rst;
            irq_out         <= {IRQ_LINES{int_pend}} & irq_sel;
        end
    end

    // Checks on the register port
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || !ce_in);

    a_base_decode: assert property (!io_data_oe_n_out |-> $past(rd_hit))
        else $error("data bus driven without an address match");
    a_card_id: assert property (rd_go && rd_ofs == `OFS_CARD_ID |=> io_data_out == CARD_ID)
        else $error("card identifier read wrong");
    a_spare_zero: assert property (rd_go && rd_ofs == `OFS_SPARE |=> io_data_out == 8'h00)
        else $error("spare offset did not read zero");
    a_baud_read: assert property (rd_go && rd_ofs == `OFS_DATA && divisor_latch_access_bit |=> io_data_out == $past(brs_r))
        else $error("baud select not visible at offset 0");
    a_rx_oldest: assert property (rd_data0 && data_ready |=> io_data_out == $past(rx_head))
        else $error("receive read did not return oldest byte");
    a_tx_push: assert property (tx_push && !tx_clr |=> !tx_empty)
        else $error("transmit write not queued");
    a_ier_write: assert property (wr_ier && !cpu_rst |=> ier_r == $past(wr_data_r[3:0]))
        else $error("interrupt enable write lost");
    a_baud_fallback: assert property (!baud_valid(brs_r) ##1 !baud_valid(brs_r) |-> baud_code_out == `BAUD_DEFAULT)
        else $error("invalid baud code not replaced by default");
    a_mode_hold: assert property (rd_lsr && pins.mode && !resp_ready_r |=> !io_data_out[`LSR_DREADY_BIT])
        else $error("mode 1 showed data before response complete");
    a_irq_route: assert property (1'b1 |=> irq_out == ({IRQ_LINES{$past(int_pend)}} & $past(irq_sel)))
        else $error("interrupt not routed to selected line");

    c_rx_read:   cover property (rd_data0 && data_ready);
    c_tx_write:  cover property (tx_push);
    c_baud_set:  cover property (wr_baud ##1 baud_valid(brs_r));
    c_cpu_reset: cover property (cpu_rst);

endmodule // host_reg_port

// ### host_reg_port_tb.sv
// Self-checking bench for the host register port, host bus driven as slow strobes.
// Assumes the link model beside the port; buffer depth shortened to 8.
`timescale 1ns/100ps

module host_reg_port_tb;
    import host_port_pkg::*;

    logic       clk_in = 1'b0;
    logic       rst_n  = 1'b0;
    logic       rd_n   = 1'b1;
    logic       wr_n   = 1'b1;
    logic [9:0] addr   = 10'h000;
    logic [7:0] wdata  = 8'h00;
    logic [6:0] base   = 7'h7F;
    logic [7:0] irq_sel = 8'h10;
    logic       mode   = 1'b0;
    logic       done   = 1'b0;
    logic       ce     = 1'b1;
    logic       remote = 1'b0;
    logic       ferr   = 1'b0;
    logic       card_rst;
    int         rst_pulses = 0;
    logic [7:0] rdata, rd, baud, irq, tx_data, rx_data;
    logic [6:0] fmt;
    logic       oe_n, oe_seen, tx_valid, tx_ready, rx_valid, rx_ready;
    int         errors = 0;
    int         checks = 0;

    // 125 MHz clock
    always #4 clk_in = ~clk_in;

    // Card reset is a one-cycle pulse, so it is counted rather than sampled
    always @(posedge clk_in)
        if (card_rst === 1'b1)
            rst_pulses <= rst_pulses + 1;

    host_reg_port #(.DEPTH(8)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n), .ce_in(ce),
        .io_rd_n_in(rd_n), .io_wr_n_in(wr_n), .io_addr_in(addr), .io_data_in(wdata),
        .io_data_out(rdata), .io_data_oe_n_out(oe_n), .base_sel_in(base), .irq_sel_in(irq_sel),
        .mode_sel_in(mode), .remote_irq_in(remote), .irq_out(irq), .tx_valid_out(tx_valid),
        .tx_data_out(tx_data), .tx_ready_in(tx_ready), .rx_valid_in(rx_valid),
        .rx_data_in(rx_data), .rx_ready_out(rx_ready), .rx_frame_err_in(ferr),
        .response_done_in(done), .baud_code_out(baud), .word_format_out(fmt), .cpu_reset_out(card_rst));

    link_model u_link (.clk_in(clk_in), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
        .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ready_in(rx_ready));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobes held at least 8 cycles low and high, beyond the filter's reach
    task automatic host_rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd_n <= 1'b0;
        repeat (8) @(posedge clk_in);
        #1 d = rdata;
        oe_seen = ~oe_n;
        @(posedge clk_in);
        rd_n <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask

    task automatic host_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr_n  <= 1'b0;
        repeat (8) @(posedge clk_in);
        wr_n <= 1'b1;
        repeat (10) @(posedge clk_in);
    endtask

    task automatic finish_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence, base 3F8 then 2E8
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_in);
        host_rd(10'h3FF, rd);
        chk("card id", 8'hA5, rd);
        chk("drive", 8'h01, {7'h00, oe_seen});
        host_wr(10'h3FF, 8'h00);
        host_rd(10'h3FF, rd);
        chk("card id after write", 8'hA5, rd);
        host_rd(10'h2FF, rd);
        chk("foreign drive", 8'h00, {7'h00, oe_seen});
        host_wr(10'h3FC, 8'hFF);
        host_rd(10'h3FC, rd);
        chk("offset 4", 8'h00, rd);
        host_wr(10'h3F9, 8'hFF);
        host_rd(10'h3F9, rd);
        chk("int enable", 8'h0F, rd);
        host_rd(10'h3FA, rd);
        chk("int id", 8'h02, rd);
        chk("irq line", 8'h10, irq);
        host_wr(10'h3F9, 8'h00);
        chk("irq off", 8'h00, irq);
        host_wr(10'h3FB, 8'h83);
        host_rd(10'h3FB, rd);
        chk("line control", 8'h83, rd);
        chk("format", 8'h03, {1'b0, fmt});
        host_wr(10'h3F8, 8'h0C);
        host_rd(10'h3F8, rd);
        chk("baud", 8'h0C, rd);
        chk("baud code", 8'h0C, baud);
        chk("no tx push", 8'h00, 8'(u_link.tx_count));
        host_wr(10'h3F8, 8'h55);
        chk("baud fallback", 8'h01, baud);
        host_wr(10'h3FB, 8'h03);
        host_wr(10'h3F8, 8'h5A);
        host_wr(10'h3F8, 8'hC3);
        chk("tx count", 8'h02, 8'(u_link.tx_count));
        chk("tx byte", 8'hC3, u_link.last_tx);
        // A write while the clock enable is low must leave no trace
        ce <= 1'b0;
        host_wr(10'h3F9, 8'h05);
        ce <= 1'b1;
        host_rd(10'h3F9, rd);
        chk("frozen write", 8'h00, rd);
        u_link.send(8'h11);
        u_link.send(8'h22);
        host_rd(10'h3F8, rd);
        chk("rx first", 8'h11, rd);
        host_rd(10'h3F8, rd);
        chk("rx second", 8'h22, rd);
        // Remote request and a framing error show in the two status offsets
        remote <= 1'b1;
        ferr   <= 1'b1;
        @(posedge clk_in);
        ferr   <= 1'b0;
        host_rd(10'h3FE, rd);
        chk("remote status", 8'h10, rd);
        host_rd(10'h3FD, rd);
        chk("framing flag", 8'h08, rd & 8'h08);
        host_rd(10'h3FD, rd);
        chk("framing cleared", 8'h00, rd & 8'h08);
        remote <= 1'b0;
        mode <= 1'b1;
        u_link.send(8'h33);
        host_rd(10'h3FD, rd);
        chk("ready early", 8'h00, rd & 8'h01);
        @(posedge clk_in);
        done <= 1'b1;
        @(posedge clk_in);
        done <= 1'b0;
        host_rd(10'h3FD, rd);
        chk("ready after response", 8'h01, rd & 8'h01);
        host_rd(10'h3F8, rd);
        chk("rx response", 8'h33, rd);
        // Card reset needs the access bit set and wipes line control
        host_wr(10'h3FB, 8'h80);
        host_wr(10'h3FA, 8'h10);
        chk("card reset pulse", 8'h01, 8'(rst_pulses));
        host_rd(10'h3FB, rd);
        chk("line control cleared", 8'h00, rd);
        base <= 7'h5D;
        repeat (8) @(posedge clk_in);
        host_rd(10'h2EF, rd);
        chk("card id new base", 8'hA5, rd);
        host_rd(10'h3FF, rd);
        chk("old base drive", 8'h00, {7'h00, oe_seen});
        chk("link stalls", 8'h00, 8'(u_link.stalls));
        finish_test();
    end

    // Hang guard
    initial
    begin
        #200000;
        errors++;
        finish_test();
    end
endmodule // host_reg_port_tb

// ### link_model.sv
// Behavioural link processor facing the card-side byte streams of the host port.
// Assumes the same clock as the port; bytes move on valid and ready both high at an edge.
`timescale 1ns/100ps

module link_model (
    input  wire logic       clk_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    input  wire logic       rx_ready_in
);
    logic [7:0] last_tx;
    int         tx_count;
    int         stalls;

    initial
    begin
        tx_ready_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_data_out  = 8'hFF;
        last_tx      = 8'h00;
        tx_count     = 0;
        stalls       = 0;
    end

    // Drain at half rate, so the port must hold a byte while stalled
    always @(posedge clk_in)
    begin
        tx_ready_out <= ~tx_ready_out;
        if (tx_valid_in && tx_ready_out)
        begin
            last_tx  <= tx_data_in;
            tx_count <= tx_count + 1;
        end
    end

    // Offer one byte and hold it until taken or 50 cycles pass; idle data shows the inverse
    task automatic send(input logic [7:0] b);
        int n;
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        rx_data_out  <= b;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_in);
            if (rx_ready_in === 1'b1)
                break;
        end
        if (n == 50)
            stalls++;
        rx_valid_out <= 1'b0;
        rx_data_out  <= ~b;
    endtask
endmodule // link_model
